// ==== hdl/rsi_defines.vh ====
// Constants for the reset state initializer: select codes, reset values,
// implemented-bit masks and interrupt vectors.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef RSI_DEFINES_VH
`define RSI_DEFINES_VH

// Register select codes on the core-side access port
`define RSI_SEL_IRQ_PRIO2   3'h0
`define RSI_SEL_PORTE_DIR   3'h1
`define RSI_SEL_PORT_A_PINS_DIR   3'h2
`define RSI_SEL_PORT_A_PINS_LAT   3'h3
`define RSI_SEL_PORT_A_PINS_PINS  3'h4
`define RSI_SEL_PORT_A_PINS_DIGEN 3'h5
`define RSI_SEL_IRQ_FLAGS   3'h6
`define RSI_SEL_STACK_PTR   3'h7

// Second interrupt priority register: reset value 11-1 1111, bit 5 absent
`define RSI_IRQ_PRIO2_RST   8'hDF
`define RSI_IRQ_PRIO2_IMPL  8'hDF

// Port E direction: reset value 0000 -111, bit 3 absent
`define RSI_PORTE_DIR_RST   8'h07
`define RSI_PORTE_DIR_IMPL  8'hF7

// Port A direction reset value
`define RSI_PORT_A_PINS_DIR_RST   8'hFF

// Port A pin bits that read as fixed zero after any reset (xx0x 0000)
`define RSI_PORT_A_PINS_ZERO_MASK 8'h2F

// Port A bits that depend on the oscillator mode
`define RSI_PORT_A_PINS_OSC_BITS  8'hC0

// Peripheral interrupt flags and digital enable reset values
`define RSI_IRQ_FLAGS_RST   8'h00
`define RSI_PORT_A_PINS_DIGEN_RST 8'h00

// Interrupt vectors, high and low priority
`define RSI_VEC_HIGH        21'h00_0008
`define RSI_VEC_LOW         21'h00_0018

// Stack pointer reset value and ceiling
`define RSI_SP_RST          5'h00
`define RSI_SP_MAX          5'h1F
`define RSI_TOS_RST         21'h00_0000

`endif

// ==== hdl/rsi_top.v ====
// Reset state initializer: loads interrupt priority, port direction, latch
// and pin-view registers per reset type, and services interrupt wake from sleep.
// Assumes the core supplies its current program counter and same-clock
// watchdog, software and stack reset pulses; master clear, brown-out and
// port A pins arrive from outside and are synchronised here.
`timescale 1ns/1ps
`include "rsi_defines.vh"

module rsi_top #(
    parameter [7:0] PORT_A_PINS_LAT_POR = 8'h00   // Power-on latch value, stands for undefined
) (
    // Clock and power-on reset
    input  wire        CLK_SYS,
    input  wire        RST,
    // Reset sources
    input  wire        BOR_PIN,
    input  wire        MASTER_CLEAR_N,
    input  wire        WATCHDOG_TIMER_RST,
    input  wire        SOFT_RST,
    input  wire        STACK_RST,
    // Wake-up events from sleep
    input  wire        WAKE_WATCHDOG,
    input  wire        WAKE_IRQ,
    input  wire        WAKE_IRQ_HIGH,
    input  wire [7:0]  WAKE_IRQ_SRC,
    input  wire        GLOBAL_IRQ_ENABLE_HIGH,
    input  wire        GLOBAL_IRQ_ENABLE_LOW,
    input  wire [20:0] CORE_PC,
    // Oscillator mode and port pins
    input  wire        OSC_FREES_PORT_A_PINS_HI,
    input  wire [7:0]  PORT_A_PIN_IN,
    // Core-side register access
    input  wire        REG_WR,
    input  wire [2:0]  REG_SEL,
    input  wire [7:0]  REG_WDATA,
    input  wire [7:0]  IRQ_FLAG_CLR,
    output reg  [7:0]  REG_RDATA,
    // Register views
    output reg  [7:0]  IRQ_PRIORITY_TWO,
    output reg  [7:0]  PORT_E_DIRECTION,
    output reg  [7:0]  PORT_A_DIRECTION,
    output reg  [7:0]  PORT_A_LATCH,
    output reg  [7:0]  PERIPH_IRQ_FLAGS,
    // Program side
    output reg         VEC_LOAD,
    output reg  [20:0] VEC_ADDR,
    output reg  [4:0]  TOP_OF_STACK_UPPER,
    output reg  [7:0]  TOP_OF_STACK_HIGH,
    output reg  [7:0]  TOP_OF_STACK_LOW,
    output reg  [4:0]  STACK_POINTER_REG
);

    // Clears bits 7 and 6 when the oscillator holds those pins
    function [7:0] rsi_osc_mask;
        input [7:0] val;
        input       freed;
        begin
            rsi_osc_mask = freed ? val : (val & ~`RSI_PORT_A_PINS_OSC_BITS);
        end
    endfunction

    // Synchroniser stages for outside inputs
    reg  [7:0]  pin_s1_q;        // First stage, read only by second
    reg  [7:0]  pin_s2_q;        // Synchronised port A pins
    reg         bor_s1_q;        // Brown-out first stage
    reg         bor_s2_q;        // Brown-out synchronised
    reg         master_clear_s1_q;       // Master clear first stage
    reg         master_clear_s2_q;       // Master clear synchronised, active low
    reg         osc_s1_q;        // Oscillator mode first stage
    reg         osc_s2_q;        // Oscillator mode synchronised

    // Held register state
    reg  [7:0]  prio2_q;         // Second interrupt priority
    reg  [7:0]  pe_dir_q;        // Port E direction
    reg  [7:0]  pa_dir_q;        // Port A direction
    reg  [7:0]  pa_lat_q;        // Port A output latch
    reg  [7:0]  pa_pins_q;       // Sampled port A pin view
    reg  [7:0]  pa_digen_q;      // Lifts forced-zero pin bits once set
    reg  [7:0]  flags_q;         // Peripheral interrupt flags
    reg  [20:0] tos_q;           // Top of stack
    reg  [4:0]  sp_q;            // Stack pointer

    // Reset classification
    wire        por_like;        // Brown-out treated as power-on
    wire        other_rst;       // Master clear, watchdog, software, stack
    wire        any_rst;         // Any synchronous reset this cycle
    wire        wake_take;       // Interrupt wake with matching enable
    wire [7:0]  pins_view;       // Pin view after zero forcing
    wire        wr_hit;          // Write accepted this cycle

    assign por_like  = bor_s2_q;
    assign other_rst = ~master_clear_s2_q | WATCHDOG_TIMER_RST | SOFT_RST | STACK_RST;
    assign any_rst   = por_like | other_rst;
    // High source needs the high enable, low source the low enable
    assign wake_take = WAKE_IRQ & ((WAKE_IRQ_HIGH & GLOBAL_IRQ_ENABLE_HIGH) |
                                   (~WAKE_IRQ_HIGH & GLOBAL_IRQ_ENABLE_LOW));
    // Writes lose to a reset in the same cycle
    assign wr_hit    = REG_WR & ~any_rst;
    // Fixed-zero bits stay zero until the digital enable lifts them
    assign pins_view = pa_pins_q & (~`RSI_PORT_A_PINS_ZERO_MASK | pa_digen_q);

    // Two-stage synchronisers; stage one feeds only stage two
    always @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            pin_s1_q  <= 8'h00;
            pin_s2_q  <= 8'h00;
            bor_s1_q  <= 1'b0;
            bor_s2_q  <= 1'b0;
            master_clear_s1_q <= 1'b1;
            master_clear_s2_q <= 1'b1;
            osc_s1_q  <= 1'b0;
            osc_s2_q  <= 1'b0;
        end
        else
        begin
            pin_s1_q  <= PORT_A_PIN_IN;
            pin_s2_q  <= pin_s1_q;
            bor_s1_q  <= BOR_PIN;
            bor_s2_q  <= bor_s1_q;
            master_clear_s1_q <= MASTER_CLEAR_N;
            master_clear_s2_q <= master_clear_s1_q;
            osc_s1_q  <= OSC_FREES_PORT_A_PINS_HI;
            osc_s2_q  <= osc_s1_q;
        end
    end

    // Configuration registers; wake-ups leave them untouched
    always @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            prio2_q    <= `RSI_IRQ_PRIO2_RST;
            pe_dir_q   <= `RSI_PORTE_DIR_RST;
            pa_dir_q   <= `RSI_PORT_A_PINS_DIR_RST;
            pa_lat_q   <= PORT_A_PINS_LAT_POR;
            pa_digen_q <= `RSI_PORT_A_PINS_DIGEN_RST;
        end
        else if (any_rst)
        begin
            // Same load for both reset classes except the latch
            prio2_q    <= `RSI_IRQ_PRIO2_RST;
            pe_dir_q   <= `RSI_PORTE_DIR_RST;
            pa_dir_q   <= `RSI_PORT_A_PINS_DIR_RST;
            pa_digen_q <= `RSI_PORT_A_PINS_DIGEN_RST;
            // Power-on class wins over coincident lesser resets
            if (por_like)
            begin
                pa_lat_q <= PORT_A_PINS_LAT_POR;
            end
            else
            begin
                pa_lat_q <= pa_lat_q;
            end
        end
        else if (wr_hit)
        begin
            case (REG_SEL)
                `RSI_SEL_IRQ_PRIO2:   prio2_q    <= REG_WDATA & `RSI_IRQ_PRIO2_IMPL;
                `RSI_SEL_PORTE_DIR:   pe_dir_q   <= REG_WDATA & `RSI_PORTE_DIR_IMPL;
                `RSI_SEL_PORT_A_PINS_DIR:   pa_dir_q   <= REG_WDATA;
                `RSI_SEL_PORT_A_PINS_LAT:   pa_lat_q   <= REG_WDATA;
                `RSI_SEL_PORT_A_PINS_DIGEN: pa_digen_q <= REG_WDATA & `RSI_PORT_A_PINS_ZERO_MASK;
                default:
                begin
                    // Flag and stack selects live in the other processes; the pin select takes no write
                    prio2_q <= prio2_q;
                end
            endcase
        end
    end

    // Pin sampling; held through a synchronous reset so unknown bits stay unchanged
    always @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            pa_pins_q <= 8'h00;
        end
        else if (!any_rst)
        begin
            pa_pins_q <= pin_s2_q;
        end
    end

    // Interrupt flags; a wake source set beats a clear in the same cycle
    always @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            flags_q <= `RSI_IRQ_FLAGS_RST;
        end
        else if (any_rst)
        begin
            flags_q <= `RSI_IRQ_FLAGS_RST;
        end
        else
        begin
            if (wr_hit && REG_SEL == `RSI_SEL_IRQ_FLAGS)
            begin
                flags_q <= REG_WDATA | (WAKE_IRQ ? WAKE_IRQ_SRC : 8'h00);
            end
            else
            begin
                flags_q <= (flags_q & ~IRQ_FLAG_CLR) |
                           (WAKE_IRQ ? WAKE_IRQ_SRC : 8'h00);
            end
        end
    end

    // Stack pointer and top of stack; wake push beats a software write
    always @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            sp_q  <= `RSI_SP_RST;
            tos_q <= `RSI_TOS_RST;
        end
        else if (any_rst)
        begin
            sp_q  <= `RSI_SP_RST;
            tos_q <= `RSI_TOS_RST;
        end
        else if (wake_take)
        begin
            tos_q <= CORE_PC;
            // Saturate so a full stack never wraps to the reset slot
            if (sp_q != `RSI_SP_MAX)
            begin
                sp_q <= sp_q + 5'h01;
            end
        end
        else if (wr_hit && REG_SEL == `RSI_SEL_STACK_PTR)
        begin
            sp_q <= REG_WDATA[4:0];
        end
    end

    // Vector load pulse on the program side, independent of data access
    always @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            VEC_LOAD <= 1'b0;
            VEC_ADDR <= `RSI_TOS_RST;
        end
        else
        begin
            VEC_LOAD <= wake_take & ~any_rst;
            if (wake_take && !any_rst)
            begin
                VEC_ADDR <= WAKE_IRQ_HIGH ? `RSI_VEC_HIGH : `RSI_VEC_LOW;
            end
        end
    end

    // Registered read port; this data path runs beside the vector path
    always @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            REG_RDATA <= 8'h00;
        end
        else
        begin
            case (REG_SEL)
                `RSI_SEL_IRQ_PRIO2:   REG_RDATA <= prio2_q & `RSI_IRQ_PRIO2_IMPL;
                `RSI_SEL_PORTE_DIR:   REG_RDATA <= pe_dir_q & `RSI_PORTE_DIR_IMPL;
                `RSI_SEL_PORT_A_PINS_DIR:   REG_RDATA <= rsi_osc_mask(pa_dir_q, osc_s2_q);
                `RSI_SEL_PORT_A_PINS_LAT:   REG_RDATA <= rsi_osc_mask(pa_lat_q, osc_s2_q);
                `RSI_SEL_PORT_A_PINS_PINS:  REG_RDATA <= rsi_osc_mask(pins_view, osc_s2_q);
                `RSI_SEL_PORT_A_PINS_DIGEN: REG_RDATA <= pa_digen_q;
                `RSI_SEL_IRQ_FLAGS:   REG_RDATA <= flags_q;
                `RSI_SEL_STACK_PTR:   REG_RDATA <= {3'h0, sp_q};
                default:
                begin
                    REG_RDATA <= 8'h00;
                end
            endcase
        end
    end

    // Registered views of the held state, one cycle behind
    always @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            IRQ_PRIORITY_TWO   <= `RSI_IRQ_PRIO2_RST;
            PORT_E_DIRECTION   <= `RSI_PORTE_DIR_RST;
            PORT_A_DIRECTION   <= 8'h00;
            PORT_A_LATCH       <= 8'h00;
            PERIPH_IRQ_FLAGS   <= `RSI_IRQ_FLAGS_RST;
            TOP_OF_STACK_UPPER <= 5'h00;
            TOP_OF_STACK_HIGH  <= 8'h00;
            TOP_OF_STACK_LOW   <= 8'h00;
            STACK_POINTER_REG  <= `RSI_SP_RST;
        end
        else
        begin
            IRQ_PRIORITY_TWO   <= prio2_q;
            PORT_E_DIRECTION   <= pe_dir_q;
            // Oscillator-held bits drive nothing when the pins are taken
            PORT_A_DIRECTION   <= rsi_osc_mask(pa_dir_q, osc_s2_q);
            PORT_A_LATCH       <= rsi_osc_mask(pa_lat_q, osc_s2_q);
            PERIPH_IRQ_FLAGS   <= flags_q;
            TOP_OF_STACK_UPPER <= tos_q[20:16];
            TOP_OF_STACK_HIGH  <= tos_q[15:8];
            TOP_OF_STACK_LOW   <= tos_q[7:0];
            STACK_POINTER_REG  <= sp_q;
        end
    end

endmodule // rsi_top

// ==== verification/rsi_top_props.sv ====
// Port checker for the reset state initializer.
// Assumes one clock domain and binding onto rsi_top.
`timescale 1ns/1ps
module rsi_props (
    input wire        CLK_SYS, RST, BOR_PIN, MASTER_CLEAR_N, VEC_LOAD,
    input wire        WATCHDOG_TIMER_RST, SOFT_RST, STACK_RST,
    input wire        WAKE_IRQ, WAKE_IRQ_HIGH, OSC_FREES_PORT_A_PINS_HI,
    input wire        GLOBAL_IRQ_ENABLE_HIGH, GLOBAL_IRQ_ENABLE_LOW,
    input wire [7:0]  WAKE_IRQ_SRC, IRQ_PRIORITY_TWO, PORT_E_DIRECTION,
    input wire [7:0]  PORT_A_DIRECTION, PORT_A_LATCH, PERIPH_IRQ_FLAGS,
    input wire [7:0]  TOP_OF_STACK_HIGH, TOP_OF_STACK_LOW,
    input wire [4:0]  TOP_OF_STACK_UPPER, STACK_POINTER_REG,
    input wire [20:0] CORE_PC, VEC_ADDR
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    // Any reset source; synced sources need quiet cycles before wakes count
    wire       any_rst = BOR_PIN | ~MASTER_CLEAR_N | WATCHDOG_TIMER_RST | SOFT_RST | STACK_RST;
    reg  [1:0] quiet_q;
    wire       quiet   = (quiet_q == 2'h3) & ~any_rst;
    wire       en_ok   = WAKE_IRQ_HIGH ? GLOBAL_IRQ_ENABLE_HIGH : GLOBAL_IRQ_ENABLE_LOW;
    wire       take    = quiet & WAKE_IRQ & en_ok;
    // Counts clean cycles since the last reset source
    always @(posedge CLK_SYS or posedge RST)
        if (RST) quiet_q <= 2'h0;
        else if (any_rst) quiet_q <= 2'h0;
        else if (quiet_q != 2'h3) quiet_q <= quiet_q + 2'h1;

    chk_vec_high: assert property (
        take && WAKE_IRQ_HIGH |=> VEC_LOAD && VEC_ADDR == 21'h00_0008)
        else $error("high vector not loaded");
    chk_vec_low: assert property (
        take && !WAKE_IRQ_HIGH |=> VEC_LOAD && VEC_ADDR == 21'h00_0018)
        else $error("low vector not loaded");
    // Cause check ignores reset quiet time: the design may take a wake sooner
    chk_vec_cause: assert property (VEC_LOAD |-> $past(WAKE_IRQ && en_ok))
        else $error("vector load without wake");
    chk_tos_copy: assert property (take |=> ##1
        {TOP_OF_STACK_UPPER, TOP_OF_STACK_HIGH, TOP_OF_STACK_LOW} == $past(CORE_PC, 2))
        else $error("top of stack not copied");
    chk_sp_advance: assert property (take |=> ##1 STACK_POINTER_REG ==
        (($past(STACK_POINTER_REG) == 5'h1F) ? 5'h1F : $past(STACK_POINTER_REG) + 5'h01))
        else $error("stack pointer not advanced");
    chk_wake_flags: assert property (quiet && WAKE_IRQ |=> ##1
        (PERIPH_IRQ_FLAGS & $past(WAKE_IRQ_SRC, 2)) == $past(WAKE_IRQ_SRC, 2))
        else $error("wake flags not set");
    chk_sync_load: assert property (
        WATCHDOG_TIMER_RST || SOFT_RST || STACK_RST |=> ##1
        IRQ_PRIORITY_TWO == 8'hDF && PORT_E_DIRECTION == 8'h07 && STACK_POINTER_REG == 5'h00)
        else $error("reset values not loaded");
    chk_unimpl_zero: assert property (
        IRQ_PRIORITY_TWO[5] == 1'h0 && PORT_E_DIRECTION[3] == 1'h0)
        else $error("unimplemented bit set");
    chk_osc_bits: assert property (!OSC_FREES_PORT_A_PINS_HI [*5] |->
        PORT_A_DIRECTION[7:6] == 2'h0 && PORT_A_LATCH[7:6] == 2'h0)
        else $error("oscillator bits not zero");
endmodule // rsi_props

bind rsi_top rsi_props u_props (
    .CLK_SYS(CLK_SYS), .RST(RST), .BOR_PIN(BOR_PIN), .MASTER_CLEAR_N(MASTER_CLEAR_N),
    .VEC_LOAD(VEC_LOAD), .WATCHDOG_TIMER_RST(WATCHDOG_TIMER_RST), .SOFT_RST(SOFT_RST),
    .STACK_RST(STACK_RST), .WAKE_IRQ(WAKE_IRQ), .WAKE_IRQ_HIGH(WAKE_IRQ_HIGH),
    .OSC_FREES_PORT_A_PINS_HI(OSC_FREES_PORT_A_PINS_HI), .GLOBAL_IRQ_ENABLE_HIGH(GLOBAL_IRQ_ENABLE_HIGH),
    .GLOBAL_IRQ_ENABLE_LOW(GLOBAL_IRQ_ENABLE_LOW), .WAKE_IRQ_SRC(WAKE_IRQ_SRC),
    .IRQ_PRIORITY_TWO(IRQ_PRIORITY_TWO), .PORT_E_DIRECTION(PORT_E_DIRECTION),
    .PORT_A_DIRECTION(PORT_A_DIRECTION), .PORT_A_LATCH(PORT_A_LATCH),
    .PERIPH_IRQ_FLAGS(PERIPH_IRQ_FLAGS), .TOP_OF_STACK_HIGH(TOP_OF_STACK_HIGH),
    .TOP_OF_STACK_LOW(TOP_OF_STACK_LOW), .TOP_OF_STACK_UPPER(TOP_OF_STACK_UPPER),
    .STACK_POINTER_REG(STACK_POINTER_REG), .CORE_PC(CORE_PC), .VEC_ADDR(VEC_ADDR)
);

// ==== verification/test_reset_state_initializer.sv ====
// Self-checking bench for the reset state initializer.
// Assumes rsi_top with its checker bound; inputs move 1 ns after each edge.
`timescale 1ns/1ps
module test_reset_state_initializer;
    // Inputs, all given a value at time zero
    logic        clk_sys = 1'h0, rst = 1'h1, bor = 1'h0, mclear_n = 1'h1, wake_dog = 1'h0;
    logic        dog_rst = 1'h0, soft_rst = 1'h0, stack_rst = 1'h0, osc = 1'h1;
    logic        wake = 1'h0, wake_hi = 1'h0, gie_h = 1'h0, gie_l = 1'h0, reg_wr = 1'h0;
    logic [2:0]  reg_sel = 3'h0;
    logic [7:0]  wake_src = 8'h00, pins = 8'hFF, wdata = 8'h00, flag_clr = 8'h00;
    logic [20:0] core_pc = 21'h00_0000;
    // Outputs
    wire  [7:0]  rdata, prio2, pe_dir, pa_dir, pa_lat, flags, tos_h, tos_l;
    wire  [4:0]  tos_u, sp;
    wire  [20:0] vec_addr;
    wire         vec_load;
    int          err_count = 0, comparisons = 0, cycles = 0;

    // Latch power-on value made visible so a lost reset load shows up
    rsi_top #(.PORT_A_PINS_LAT_POR(8'h5A)) DUT (
        .CLK_SYS(clk_sys), .RST(rst), .BOR_PIN(bor), .MASTER_CLEAR_N(mclear_n),
        .WATCHDOG_TIMER_RST(dog_rst), .SOFT_RST(soft_rst), .STACK_RST(stack_rst),
        .WAKE_WATCHDOG(wake_dog), .WAKE_IRQ(wake), .WAKE_IRQ_HIGH(wake_hi),
        .WAKE_IRQ_SRC(wake_src), .GLOBAL_IRQ_ENABLE_HIGH(gie_h), .GLOBAL_IRQ_ENABLE_LOW(gie_l),
        .CORE_PC(core_pc), .OSC_FREES_PORT_A_PINS_HI(osc), .PORT_A_PIN_IN(pins), .REG_WR(reg_wr),
        .REG_SEL(reg_sel), .REG_WDATA(wdata), .IRQ_FLAG_CLR(flag_clr), .REG_RDATA(rdata),
        .IRQ_PRIORITY_TWO(prio2), .PORT_E_DIRECTION(pe_dir), .PORT_A_DIRECTION(pa_dir),
        .PORT_A_LATCH(pa_lat), .PERIPH_IRQ_FLAGS(flags), .VEC_LOAD(vec_load),
        .VEC_ADDR(vec_addr), .TOP_OF_STACK_UPPER(tos_u), .TOP_OF_STACK_HIGH(tos_h),
        .TOP_OF_STACK_LOW(tos_l), .STACK_POINTER_REG(sp)
    );

    // 125 MHz clock
    always #4 clk_sys = ~clk_sys;

    // Hang guard: the whole run needs about 150 cycles
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            err_count++;
            results();
        end
    end

    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Gap cycle after each write keeps strobe edges in separate steps
    task automatic wr(input logic [2:0] s, input logic [7:0] d);
        reg_wr = 1'h1;
        reg_sel = s;
        wdata = d;
        tick();
        reg_wr = 1'h0;
        tick();
    endtask

    task automatic rd(input logic [2:0] s, input logic [7:0] exp, input string what);
        reg_sel = s;
        tick(2);
        chk(what, exp, rdata);
    endtask

    task automatic t_por;
        chk("prio2", 8'hDF, prio2);
        chk("pe_dir", 8'h07, pe_dir);
        chk("sp", 5'h00, sp);
        chk("pa_lat", 8'h5A, pa_lat);
        rd(3'h4, 8'hD0, "pins");
        $display("por done");
    endtask

    // Writes of all ones must leave the missing bits at zero
    task automatic t_mask;
        wr(3'h0, 8'hFF);
        rd(3'h0, 8'hDF, "prio2 rd");
        wr(3'h1, 8'hFF);
        rd(3'h1, 8'hF7, "pe_dir rd");
        $display("mask done");
    endtask

    // Each non power-on source in turn: loads, but latch is kept
    task automatic t_sync;
        for (int k = 0; k < 4; k++)
        begin
            wr(3'h0, 8'h00);
            wr(3'h1, 8'h00);
            wr(3'h3, 8'h3C);
            wr(3'h7, 8'h05);
            mclear_n = (k != 0);
            dog_rst = (k == 1);
            soft_rst = (k == 2);
            stack_rst = (k == 3);
            tick(2);
            mclear_n = 1'h1;
            dog_rst = 1'h0;
            soft_rst = 1'h0;
            stack_rst = 1'h0;
            tick(5);
            chk("prio2", 8'hDF, prio2);
            chk("pe_dir", 8'h07, pe_dir);
            chk("pa_lat", 8'h3C, pa_lat);
            chk("sp", 5'h00, sp);
            rd(3'h4, 8'hD0, "pins");
        end
        $display("sync done");
    endtask

    // Brown-out together with master clear: power-on class wins
    task automatic t_bor;
        wr(3'h3, 8'h3C);
        bor = 1'h1;
        mclear_n = 1'h0;
        tick(2);
        bor = 1'h0;
        mclear_n = 1'h1;
        tick(5);
        chk("pa_lat", 8'h5A, pa_lat);
        $display("bor done");
    endtask

    task automatic wake_do(input logic hi, eh, el, input logic [20:0] pc,
                           input logic [7:0] src, input logic vl, input logic [4:0] esp);
        wake = 1'h1;
        wake_hi = hi;
        gie_h = eh;
        gie_l = el;
        core_pc = pc;
        wake_src = src;
        tick();
        wake = 1'h0;
        chk("vec_load", vl, vec_load);
        if (vl) chk("vec_addr", hi ? 21'h00_0008 : 21'h00_0018, vec_addr);
        tick();
        if (vl) chk("tos", pc, {tos_u, tos_h, tos_l});
        chk("sp", esp, sp);
        chk("flags", src, flags & src);
    endtask

    // Enabled and refused wakes back to back, then a full stack
    task automatic t_wake;
        wr(3'h7, 8'h00);
        wr(3'h6, 8'h00);
        wake_do(1'h1, 1'h1, 1'h0, 21'h1F_1234, 8'h01, 1'h1, 5'h01);
        wake_do(1'h0, 1'h0, 1'h1, 21'h0A_5678, 8'h80, 1'h1, 5'h02);
        wake_do(1'h1, 1'h0, 1'h1, 21'h00_0100, 8'h04, 1'h0, 5'h02);
        wake_do(1'h0, 1'h1, 1'h0, 21'h00_0200, 8'h10, 1'h0, 5'h02);
        wr(3'h7, 8'h1F);
        // Clear held on the waking bit: the set must win its cycle, then clear
        flag_clr = 8'h02;
        wake_do(1'h1, 1'h1, 1'h1, 21'h12_3456, 8'h02, 1'h1, 5'h1F);
        flag_clr = 8'h00;
        wake_dog = 1'h1;
        tick();
        wake_dog = 1'h0;
        flag_clr = 8'h80;
        tick();
        flag_clr = 8'h00;
        tick(2);
        chk("prio2", 8'hDF, prio2);
        chk("flags", 8'h15, flags);
        $display("wake done");
    endtask

    // Oscillator holding the top port bits: they read zero
    task automatic t_osc;
        wr(3'h3, 8'hFF);
        osc = 1'h0;
        tick(6);
        chk("pa_dir", 8'h3F, pa_dir);
        chk("pa_lat", 8'h3F, pa_lat);
        rd(3'h4, 8'h10, "pins");
        osc = 1'h1;
        tick(6);
        chk("pa_lat", 8'hFF, pa_lat);
        $display("osc done");
    endtask

    // Digital enable lifts forced-zero pin bits; a mid-run power-on drops it
    task automatic t_digen;
        wr(3'h5, 8'hFF);
        wr(3'h4, 8'h00);
        rd(3'h4, 8'hFF, "pins lifted");
        wr(3'h2, 8'h0F);
        chk("pa_dir", 8'h0F, pa_dir);
        rst = 1'h1;
        tick(2);
        rst = 1'h0;
        tick(6);
        chk("pa_dir", 8'hFF, pa_dir);
        chk("pa_lat", 8'h5A, pa_lat);
        rd(3'h4, 8'hD0, "pins");
        $display("digen done");
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        tick(2);
        rst = 1'h0;
        tick(6);
        t_por();
        t_mask();
        t_sync();
        t_bor();
        t_wake();
        t_osc();
        t_digen();
        results();
    end
endmodule // test_reset_state_initializer
